// ===== gateway_control_byte_handshake.sv
// control-byte interpreter of a fieldbus-to-serial gateway
// assumes the fieldbus cycle, control and data bytes, serial byte stream and
// configuration levels all come from logic on i_mclk, so no synchronisers
`timescale 1ns/1ns
`include "gateway_regs.svh"

module gateway_control_byte_handshake (
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst,
    // fieldbus cycle
    input  wire logic                     i_cycle,
    input  wire logic [7:0]               i_mode_address_control_byte,
    input  wire logic [7:0]               i_buffer_handshake_control_byte,
    input  wire gateway_pkg::data_t       i_out_data,
    // configuration
    input  wire logic                     i_collective_mode,
    input  wire logic                     i_mux_attached,
    input  wire logic [3:0]               i_telegram_len,
    // serial transmit stream
    output logic                          o_tx_valid,
    output logic [7:0]                    o_tx_byte,
    input  wire logic                     i_tx_ready,
    // serial receive stream
    input  wire logic                     i_rx_valid,
    input  wire logic [7:0]               i_rx_byte,
    output logic                          o_rx_ready,
    // fieldbus input side
    output gateway_pkg::data_t            o_in_data,
    output logic [3:0]                    o_in_len,
    output logic                          o_block_ready_toggle,
    output logic                          o_rx_pending,
    output logic                          o_tx_overflow,
    // command mode
    output logic                          o_cmd_strobe,
    output gateway_pkg::data_t            o_cmd_data,
    output logic                          o_busy
);
    gateway_pkg::gw_core_s st;
    gateway_pkg::gw_core_s next_st;

    logic                 tx_push;
    logic                 tx_pop;
    logic                 tx_clear;
    logic [7:0]           tx_rd;
    logic                 tx_empty;
    logic                 tx_full;
    logic                 rx_push;
    logic                 rx_pop;
    logic [7:0]           rx_rd;
    logic [`GW_CNT_W-1:0] rx_count;
    logic                 rx_empty;
    logic                 can_load;
    logic                 collective;
    logic                 cmd_mode;
    logic                 new_set;
    logic                 rack_chg;
    logic                 sfb_chg;
    logic                 ctb_chg;
    logic [3:0]           tlen;
    logic [3:0]           pre_len;
    logic [3:0]           data_idx;
    logic [7:0]           out_byte;
    logic [4:0]           addr;

    // ==========================================================
    // prefix byte for a multiplexer telegram
    function automatic logic [7:0] prefix_byte(input logic [7:0] c0, input logic [3:0] k);
        logic [4:0] a;
        logic [3:0] tens;
        logic [3:0] ones;
        a    = c0[`GW_C0_ADDR_HI:`GW_C0_ADDR_LO];
        tens = (a >= 5'd30) ? 4'd3 : (a >= 5'd20) ? 4'd2 : (a >= 5'd10) ? 4'd1 : 4'd0;
        // product kept at five bits, four would wrap at twenty
        ones = 4'(a - (5'(tens) * 5'd10));
        if (c0[`GW_C0_BROADCAST]) begin
            prefix_byte = (k == 4'd2) ? `GW_ASCII_BCAST : `GW_ASCII_ZERO;
        end else if (k == 4'd0) begin
            prefix_byte = `GW_ASCII_ZERO + {4'h0, tens};
        end else begin
            prefix_byte = `GW_ASCII_ZERO + {4'h0, ones};
        end
    endfunction

    // ==========================================================
    // decode of latched control bytes, of the incoming data set and of the configuration
    always_comb begin
        collective = i_collective_mode;
        cmd_mode   = st.ctrl0[`GW_C0_CMD_MODE];
        rack_chg   = st.ctrl1[`GW_C1_READ_ACK] ^ st.prev_rack;
        sfb_chg    = st.ctrl1[`GW_C1_SEND_BUF] ^ st.prev_sfb;
        ctb_chg    = st.ctrl1[`GW_C1_COPY_BUF] ^ st.prev_ctb;
        new_set    = (i_mode_address_control_byte[`GW_C0_NEW_DATA] != st.prev_nd)
                     || (i_out_data != st.data);
        addr       = st.ctrl0[`GW_C0_ADDR_HI:`GW_C0_ADDR_LO];
        if (i_telegram_len == 4'd0) begin
            tlen = 4'd1;
        end else if (i_telegram_len > 4'(`GW_DATA_BYTES)) begin
            tlen = 4'(`GW_DATA_BYTES);
        end else begin
            tlen = i_telegram_len;
        end
        // without a multiplexer the prefix fields mean nothing
        if (!i_mux_attached) begin
            pre_len = 4'd0;
        end else if (st.ctrl0[`GW_C0_BROADCAST]) begin
            pre_len = `GW_BCAST_LEN;
        end else begin
            pre_len = `GW_ADDR_LEN;
        end
        can_load = !st.tx_valid || i_tx_ready;
        data_idx = st.idx - st.pre_len;
        if (st.idx < st.pre_len) begin
            out_byte = prefix_byte(st.snap_ctrl0, st.idx);
        end else begin
            out_byte = st.snap[data_idx];
        end
        rx_push = i_rx_valid && st.rx_ready;
    end

    // ==========================================================
    // main sequencer
    always_comb begin
        next_st            = st;
        next_st.cmd_strobe = 1'b0;
        tx_push            = 1'b0;
        tx_pop             = 1'b0;
        tx_clear           = 1'b0;
        rx_pop             = 1'b0;
        if (st.tx_valid && i_tx_ready) begin
            next_st.tx_valid = 1'b0;
        end

        case (st.state)
            gateway_pkg::ST_IDLE: begin
                if (!collective) begin
                    // keep handshake history aligned so a mode switch fires nothing
                    next_st.prev_rack = st.ctrl1[`GW_C1_READ_ACK];
                    next_st.prev_sfb  = st.ctrl1[`GW_C1_SEND_BUF];
                    next_st.prev_ctb  = st.ctrl1[`GW_C1_COPY_BUF];
                end
                if (collective && rack_chg) begin
                    next_st.prev_rack = st.ctrl1[`GW_C1_READ_ACK];
                    next_st.in_data   = '0;
                    if (!rx_empty) begin
                        next_st.state = gateway_pkg::ST_FILL;
                        next_st.idx   = 4'd0;
                    end else begin
                        next_st.in_len = 4'd0;
                    end
                end else if (collective && ctb_chg) begin
                    // copy beats send in the same cycle so the buffer holds it first
                    next_st.prev_ctb = st.ctrl1[`GW_C1_COPY_BUF];
                    next_st.data_new = 1'b0;
                    if (!cmd_mode) begin
                        next_st.state    = gateway_pkg::ST_APPEND;
                        next_st.idx      = 4'd0;
                        next_st.send_len = tlen;
                        next_st.snap     = st.data;
                    end
                end else if (collective && sfb_chg) begin
                    next_st.prev_sfb = st.ctrl1[`GW_C1_SEND_BUF];
                    next_st.state    = gateway_pkg::ST_DRAIN;
                end else if (st.data_new) begin
                    next_st.data_new = 1'b0;
                    if (cmd_mode) begin
                        next_st.cmd_strobe = 1'b1;
                        next_st.cmd_data   = st.data;
                    end else begin
                        next_st.state      = gateway_pkg::ST_DIRECT;
                        next_st.idx        = 4'd0;
                        next_st.pre_len    = pre_len;
                        next_st.send_len   = pre_len + tlen;
                        next_st.snap       = st.data;
                        next_st.snap_ctrl0 = st.ctrl0;
                    end
                end
            end
            gateway_pkg::ST_DIRECT: begin
                if (can_load) begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_byte  = out_byte;
                    next_st.idx      = st.idx + 4'd1;
                    if (st.idx == st.send_len - 4'd1) begin
                        next_st.state = gateway_pkg::ST_IDLE;
                    end
                end
            end
            gateway_pkg::ST_APPEND: begin
                // a full buffer drops the byte; stalling would deadlock the send
                if (tx_full) begin
                    next_st.tx_overflow = 1'b1;
                end else begin
                    tx_push = 1'b1;
                end
                next_st.idx = st.idx + 4'd1;
                if (st.idx == st.send_len - 4'd1) begin
                    next_st.state = gateway_pkg::ST_IDLE;
                end
            end
            gateway_pkg::ST_DRAIN: begin
                if (tx_empty) begin
                    next_st.state       = gateway_pkg::ST_IDLE;
                    next_st.tx_overflow = 1'b0;
                end else if (can_load) begin
                    tx_pop           = 1'b1;
                    next_st.tx_valid = 1'b1;
                    next_st.tx_byte  = tx_rd;
                end
            end
            gateway_pkg::ST_FILL: begin
                if (rx_empty || st.idx == 4'(`GW_DATA_BYTES)) begin
                    next_st.in_len = st.idx;
                    next_st.block_ready_toggle    = ~st.block_ready_toggle;
                    next_st.state  = gateway_pkg::ST_IDLE;
                end else begin
                    rx_pop                   = 1'b1;
                    next_st.in_data[st.idx]  = rx_rd;
                    next_st.idx              = st.idx + 4'd1;
                end
            end
            default: begin
                next_st.state = gateway_pkg::ST_IDLE;
            end
        endcase

        // a new set arriving in the cycle it is consumed is kept
        if (i_cycle) begin
            next_st.ctrl0   = i_mode_address_control_byte;
            next_st.ctrl1   = i_buffer_handshake_control_byte;
            next_st.data    = i_out_data;
            next_st.prev_nd = i_mode_address_control_byte[`GW_C0_NEW_DATA];
            if (new_set) begin
                next_st.data_new = 1'b1;
            end
        end
        next_st.rx_ready   = (rx_count < `GW_RX_HIGH);
        next_st.rx_pending = !(rx_empty && !rx_push) || (rx_pop && rx_count > 11'd1);
        next_st.busy       = (next_st.state != gateway_pkg::ST_IDLE);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st            <= '0;
            st.state      <= gateway_pkg::ST_IDLE;
            st.ctrl0      <= `GW_CTRL_RESET;
            st.ctrl1      <= `GW_CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // one kilobyte each way
    byte_fifo tx_buf (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_clear   (tx_clear),
        .i_push    (tx_push),
        .i_data    (st.snap[st.idx]),
        .i_pop     (tx_pop),
        .o_rd_data (tx_rd),
        .o_count   (),
        .o_empty   (tx_empty),
        .o_full    (tx_full)
    );

    byte_fifo rx_buf (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_clear   (1'b0),
        .i_push    (rx_push),
        .i_data    (i_rx_byte),
        .i_pop     (rx_pop),
        .o_rd_data (rx_rd),
        .o_count   (rx_count),
        .o_empty   (rx_empty),
        .o_full    ()
    );

    // ==========================================================
    // outputs, all from the state register
    assign o_tx_valid           = st.tx_valid;
    assign o_tx_byte            = st.tx_byte;
    assign o_rx_ready           = st.rx_ready;
    assign o_in_data            = st.in_data;
    assign o_in_len             = st.in_len;
    assign o_block_ready_toggle = st.block_ready_toggle;
    assign o_rx_pending         = st.rx_pending;
    assign o_tx_overflow        = st.tx_overflow;
    assign o_cmd_strobe         = st.cmd_strobe;
    assign o_cmd_data           = st.cmd_data;
    assign o_busy               = st.busy;
endmodule

// ===== gateway_regs.svh
// bit positions, reset values and sizes of the control-byte gateway
// assumes inclusion from the package, the gateway and the byte buffer; definitions only, no logic
`ifndef GATEWAY_REGS_SVH
`define GATEWAY_REGS_SVH

// ==========================================================
// control byte 0 (mode_address_control_byte) bit positions
`define GW_C0_CMD_MODE      0
`define GW_C0_BROADCAST     1
`define GW_C0_ADDR_LO       2
`define GW_C0_ADDR_HI       6
`define GW_C0_NEW_DATA      7

// ==========================================================
// control byte 1 (buffer_handshake_control_byte) bit positions
`define GW_C1_READ_ACK      0
`define GW_C1_SEND_BUF      2
`define GW_C1_COPY_BUF      3

// ==========================================================
// reset values
`define GW_CTRL_RESET       8'h00
`define GW_BYTE_ZERO        8'h00

// ==========================================================
// sizes
`define GW_DATA_BYTES       4
`define GW_BUF_DEPTH        1024
`define GW_PTR_W            10
`define GW_CNT_W            11
`define GW_RX_HIGH          11'h03fe

// ==========================================================
// prefix characters sent ahead of a telegram to a network multiplexer
`define GW_ASCII_ZERO       8'h30
`define GW_ASCII_BCAST      8'h42
`define GW_BCAST_LEN        4'h3
`define GW_ADDR_LEN         4'h2

`endif

// ===== gateway_pkg.sv
// types shared by the control-byte gateway and its byte buffer
// assumes gateway_regs.svh is on the include path
`include "gateway_regs.svh"

package gateway_pkg;

    // ==========================================================
    // states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b0_0001,
        ST_DIRECT = 5'b0_0010,
        ST_APPEND = 5'b0_0100,
        ST_DRAIN  = 5'b0_1000,
        ST_FILL   = 5'b1_0000
    } gw_state_e;

    // ==========================================================
    // carriers
    typedef logic [`GW_DATA_BYTES-1:0][7:0] data_t;

    typedef struct packed {
        logic [`GW_PTR_W-1:0] wr_ptr;
        logic [`GW_PTR_W-1:0] rd_ptr;
        logic [`GW_CNT_W-1:0] count;
    } fifo_ptr_s;

    typedef struct packed {
        gw_state_e  state;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic       prev_nd;
        logic       prev_rack;
        logic       prev_sfb;
        logic       prev_ctb;
        data_t      data;
        data_t      snap;
        logic [7:0] snap_ctrl0;
        logic       data_new;
        logic [3:0] idx;
        logic [3:0] pre_len;
        logic [3:0] send_len;
        logic       tx_valid;
        logic [7:0] tx_byte;
        data_t      in_data;
        logic [3:0] in_len;
        logic       block_ready_toggle;
        logic       cmd_strobe;
        data_t      cmd_data;
        logic       rx_ready;
        logic       rx_pending;
        logic       tx_overflow;
        logic       busy;
    } gw_core_s;

endpackage

// ===== byte_fifo.sv
// byte buffer of GW_BUF_DEPTH entries with show-ahead read
// assumes push is never given while full nor pop while empty
`timescale 1ns/1ns
`include "gateway_regs.svh"

module byte_fifo (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    input  wire logic                 i_clear,
    input  wire logic                 i_push,
    input  wire logic [7:0]           i_data,
    input  wire logic                 i_pop,
    output logic      [7:0]           o_rd_data,
    output logic      [`GW_CNT_W-1:0] o_count,
    output logic                      o_empty,
    output logic                      o_full
);
    logic [7:0]             mem [`GW_BUF_DEPTH];
    gateway_pkg::fifo_ptr_s st;
    gateway_pkg::fifo_ptr_s next_st;

    always_comb begin
        next_st = st;
        if (i_clear) begin
            next_st = '0;
        end else begin
            if (i_push) begin
                next_st.wr_ptr = st.wr_ptr + 1'b1;
            end
            if (i_pop) begin
                next_st.rd_ptr = st.rd_ptr + 1'b1;
            end
            case ({i_push, i_pop})
                2'b10:   next_st.count = st.count + 1'b1;
                2'b01:   next_st.count = st.count - 1'b1;
                default: next_st.count = st.count;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // memory carries no reset; empty pointers keep stale bytes unread
    always_ff @(posedge i_mclk) begin
        if (i_push && !i_clear) begin
            mem[st.wr_ptr] <= i_data;
        end
    end

    assign o_rd_data = mem[st.rd_ptr];
    assign o_count   = st.count;
    assign o_empty   = (st.count == '0);
    assign o_full    = (st.count == `GW_CNT_W'(`GW_BUF_DEPTH));
endmodule

// ===== gw_props.sv
// port checker for the control-byte gateway
// assumes it is bound onto the gateway top module, one clock domain
`timescale 1ns/1ns
module gw_props (
    input wire logic               i_mclk,
    input wire logic               i_rst,
    input wire logic               i_cycle,
    input wire logic [7:0]         i_mode_address_control_byte,
    input wire logic [7:0]         i_buffer_handshake_control_byte,
    input wire gateway_pkg::data_t i_out_data,
    input wire logic               i_tx_ready,
    input wire logic               o_tx_valid,
    input wire logic [7:0]         o_tx_byte,
    input wire logic [3:0]         o_in_len,
    input wire logic               o_block_ready_toggle,
    input wire logic               o_cmd_strobe,
    input wire logic               o_busy
);
    // ==========
    // last latched bytes, so a new data set can be spotted
    gateway_pkg::data_t last_d;
    logic [7:0]         last_c0;
    logic [7:0]         last_c1;
    logic               new_set;
    logic               calm;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            last_d  <= '0;
            last_c0 <= 8'h00;
            last_c1 <= 8'h00;
        end else if (i_cycle) begin
            last_d  <= i_out_data;
            last_c0 <= i_mode_address_control_byte;
            last_c1 <= i_buffer_handshake_control_byte;
        end
    end
    assign new_set = i_cycle && (i_out_data != last_d
                     || i_mode_address_control_byte[7] != last_c0[7]);
    // no handshake flip pending, so the new set is the only event
    assign calm = !o_busy && !o_tx_valid && i_buffer_handshake_control_byte == last_c1;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // ==========
    // assertions
    a_tx_hold:
        assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
        else $error("tx byte changed before it was taken");
    a_direct_start:
        assert property (new_set && calm && !$past(o_busy) && !i_mode_address_control_byte[0]
            |-> ##[2:3] o_tx_valid) else $error("new data set sent no telegram");
    a_cmd_start:
        assert property (new_set && calm && !$past(o_busy) && i_mode_address_control_byte[0]
            |-> ##[2:3] o_cmd_strobe) else $error("command set gave no strobe");
    a_cmd_silent:
        assert property (new_set && calm && i_mode_address_control_byte[0]
            |=> !o_tx_valid [*4]) else $error("command set reached the serial port");
    // a set latched in the cycle before the strobe may legally give a second strobe
    a_cmd_pulse:
        assert property (o_cmd_strobe && !$past(new_set) |=> !o_cmd_strobe)
        else $error("command strobe longer than one cycle");
    // last byte may still wait for the sink after the sequencer went idle
    a_busy_tx:
        assert property ($rose(o_tx_valid) |-> $past(o_busy))
        else $error("tx while sequencer idle");
    a_blr_data:
        assert property ($changed(o_block_ready_toggle) |-> o_in_len != 4'h0)
        else $error("block ready flipped without data");
    a_len_limit:
        assert property (o_in_len <= 4'h4) else $error("input length above four");
endmodule

bind gateway_control_byte_handshake gw_props i_props (
    .i_mclk, .i_rst, .i_cycle, .i_mode_address_control_byte,
    .i_buffer_handshake_control_byte, .i_out_data, .i_tx_ready, .o_tx_valid,
    .o_tx_byte, .o_in_len, .o_block_ready_toggle, .o_cmd_strobe, .o_busy
);

// ===== serial_end_model.sv
// serial end device: stalling byte sink and burst byte source
// assumes all changes land 1 ns after the rising clock edge
`timescale 1ns/1ns
module serial_end_model #(parameter int RX_BURST = 6) (
    input  wire logic       i_mclk,
    input  wire logic       i_rx_go,
    input  wire logic       i_rx_ready,
    output logic            o_tx_ready,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_byte
);
    // ==========
    // source bytes count up from 8'h61
    integer     seed = 56;
    int         left = 0;
    logic       taken;
    logic [7:0] nxt = 8'h61;
    initial begin
        o_tx_ready = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_byte  = 8'h00;
    end
    always @(posedge i_mclk) begin
        taken = o_rx_valid && i_rx_ready;
        if (i_rx_go) left = RX_BURST;
        #1;
        o_tx_ready = 1'($random(seed));
        if (taken) begin
            nxt++;
            left--;
        end
        o_rx_valid = left > 0;
        // released line alternates the last byte and its inverse, never a steady byte
        o_rx_byte = (left > 0) ? nxt : ~o_rx_byte;
    end
endmodule

// ===== tb_gateway_control_byte_handshake.sv
// self-checking bench for the control-byte gateway
// assumes serial_end_model and the bound port checker are compiled first
`timescale 1ns/1ns
module tb_gateway_control_byte_handshake;
    // ==========
    // signals
    logic               i_mclk = 1'b0;
    logic               i_rst = 1'b1;
    logic               i_cycle = 1'b0;
    logic               i_collective_mode = 1'b0;
    logic               i_mux_attached = 1'b0;
    logic               rx_go = 1'b0;
    logic               blr_q = 1'b0;
    logic [3:0]         i_telegram_len = 4'h4;
    logic [7:0]         c0 = 8'h00;
    logic [7:0]         c1 = 8'h00;
    logic [7:0]         a = 8'h00;
    gateway_pkg::data_t i_out_data = '0;
    gateway_pkg::data_t d, o_in_data, o_cmd_data;
    logic               i_tx_ready, i_rx_valid, o_tx_valid, o_rx_ready;
    logic               o_block_ready_toggle, o_cmd_strobe, o_busy;
    logic               o_rx_pending, o_tx_overflow;
    logic [7:0]         i_rx_byte, o_tx_byte;
    logic [3:0]         o_in_len;
    logic [7:0]         txq[$];
    logic [35:0]        wq[$];
    integer             fail_count = 0;
    integer             checked = 0;
    integer             seed = 56;
    always #10 i_mclk = ~i_mclk;
    gateway_control_byte_handshake i_dut (
        .i_mclk, .i_rst, .i_cycle, .i_mode_address_control_byte(c0),
        .i_buffer_handshake_control_byte(c1), .i_out_data, .i_collective_mode,
        .i_mux_attached, .i_telegram_len, .o_tx_valid, .o_tx_byte, .i_tx_ready,
        .i_rx_valid, .i_rx_byte, .o_rx_ready, .o_in_data, .o_in_len,
        .o_block_ready_toggle, .o_rx_pending, .o_tx_overflow, .o_cmd_strobe,
        .o_cmd_data, .o_busy
    );
    serial_end_model i_far (
        .i_mclk, .i_rx_go(rx_go), .i_rx_ready(o_rx_ready),
        .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte)
    );
    // ==========
    // tasks
    task automatic cmp_word(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_word({28'h0, got}, {28'h0, exp});
    endtask
    function automatic logic [35:0] shown(input logic [3:0] n, input gateway_pkg::data_t v);
        for (int i = 0; i < 4; i++) if (i >= n) v[i] = 8'h00;
        return {n, v};
    endfunction
    task automatic tele(input logic [7:0] b, input gateway_pkg::data_t v);
        int len;
        len = (i_telegram_len == 4'h0) ? 1 : (i_telegram_len > 4'h4 ? 4 : i_telegram_len);
        if (i_mux_attached && b[1]) begin
            txq.push_back(8'h30);
            txq.push_back(8'h30);
            txq.push_back(8'h42);
        end else if (i_mux_attached) begin
            txq.push_back(8'h30 + b[6:2] / 10);
            txq.push_back(8'h30 + b[6:2] % 10);
        end
        for (int i = 0; i < len; i++) txq.push_back(v[i]);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while ((o_busy !== 1'b0 || txq.size() != 0) && n < 300) begin
            @(posedge i_mclk);
            n++;
        end
        if (n == 300) begin
            fail_count++;
            $display("wrong value at %0t: sequencer stuck", $time);
        end
        #1;
    endtask
    task automatic cyc(input logic [7:0] b0, input logic [7:0] b1, input gateway_pkg::data_t v);
        @(posedge i_mclk);
        #1;
        c0 = b0;
        c1 = b1;
        i_out_data = v;
        i_cycle = 1'b1;
        @(posedge i_mclk);
        #1;
        i_cycle = 1'b0;
        repeat (3) @(posedge i_mclk);
        wait_idle;
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========
    // result watcher: oldest note against each result seen
    always @(posedge i_mclk) begin
        if (!i_rst && o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
            cmp_byte(o_tx_byte, txq.size() ? txq.pop_front() : 8'hxx);
        end
        if (!i_rst && o_block_ready_toggle !== blr_q) begin
            cmp_word(shown(o_in_len, o_in_data), wq.size() ? wq.pop_front() : 36'hx);
        end
        if (!i_rst && o_cmd_strobe === 1'b1) begin
            cmp_word({4'h0, o_cmd_data}, wq.size() ? wq.pop_front() : 36'hx);
        end
        blr_q = o_block_ready_toggle;
    end
    initial begin
        #200000;
        fail_count++;
        print_verdict;
    end
    // ==========
    // main sequence
    initial begin
        repeat (10) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        for (int k = 0; k < 12; k++) begin
            i_mux_attached = k[0];
            i_telegram_len = 4'(k % 6);
            a = {a[7], 7'($random(seed))} & 8'hfe;
            d = $random(seed);
            tele(a, d);
            cyc(a, 8'h00, d);
        end
        // same data again, marked new only by the toggle
        i_mux_attached = 1'b1;
        a = {~a[7], 7'h7c};
        tele(a, d);
        cyc(a, 8'h00, d);
        d = $random(seed);
        wq.push_back({4'h0, d});
        cyc(8'h01, 8'h00, d);
        i_collective_mode = 1'b1;
        i_mux_attached = 1'b0;
        cyc(8'h00, 8'h08, 32'h0403_0201);
        cyc(8'h00, 8'h00, 32'h0807_0605);
        for (int i = 1; i < 9; i++) txq.push_back(8'(i));
        cyc(8'h00, 8'h04, 32'h0807_0605);
        cyc(8'h00, 8'h00, 32'h0807_0605);
        cmp_byte({7'h00, o_tx_overflow}, 8'h00);
        i_collective_mode = 1'b0;
        tele(8'h00, 32'h0c0b_0a09);
        cyc(8'h00, 8'h08, 32'h0c0b_0a09);
        i_collective_mode = 1'b1;
        @(posedge i_mclk);
        #1 rx_go = 1'b1;
        @(posedge i_mclk);
        #1 rx_go = 1'b0;
        repeat (20) @(posedge i_mclk);
        #1;
        cmp_byte({7'h00, o_rx_pending}, 8'h01);
        wq.push_back(36'h4_6463_6261);
        cyc(8'h00, 8'h09, 32'h0c0b_0a09);
        wq.push_back(36'h2_0000_6665);
        cyc(8'h00, 8'h08, 32'h0c0b_0a09);
        cyc(8'h00, 8'h09, 32'h0c0b_0a09);
        cmp_word({o_in_len, o_in_data}, 36'h0);
        cmp_byte({7'h00, o_rx_pending}, 8'h00);
        print_verdict;
    end
endmodule
